// ===== rtl/mstp_defines.vh
// Purpose: Constants for the step translator and chopper
// Assumes: 50 MHz aclk
// Notes: Times in ns, counts derived
`ifndef MSTP_DEFINES_VH
`define MSTP_DEFINES_VH
`define MSTP_CLK_NS 20
`define MSTP_TOFF_NS 30000
`define MSTP_TBLANK_NS 1000
`define MSTP_TOFF_CYC (`MSTP_TOFF_NS / `MSTP_CLK_NS)
`define MSTP_TBLANK_CYC (`MSTP_TBLANK_NS / `MSTP_CLK_NS)
`define MSTP_FAST_CYC ((`MSTP_TOFF_CYC * 3125) / 10000)
`define MSTP_POS_HOME 6'h08
`define MSTP_ADDR_CTRL 4'h0
`define MSTP_ADDR_STAT 4'h4
`define MSTP_ADDR_LEVEL 4'h8
`define MSTP_CTRL_RST 2'h0
`define MSTP_DEC_MIXED 1'b1
`define MSTP_DEC_SLOW 1'b0
`endif

// ===== rtl/mstp_translator.v
// Purpose: Step/direction translator with fixed off-time chopping for two bridges
// Assumes: Comparator inputs are async; level outputs feed external DACs
// Notes: Control and status via AXI4-Lite
//
// Functional notes
// - Rising advance edge moves one increment
// - Select inputs choose full/half/quarter/sixteenth increment
// - Select changes apply at next advance edge
// - Direction sampled only at advance edge
// - Reset loads Home, both bridges Mixed
// - Falling level selects Mixed decay
// - Rising or equal level selects Slow
// - Reset holds Home, all transistors off
// - Advance pulses ignored during reset
// - On-phase enables diagonal source/sink pair
// - Comparator trip ends on-phase
// - Slow: source off; Mixed: both off
// - Reference scaled by level, full is /8
// - Grounded off-time pin forces Mixed, 30us
// - Fault or power-down returns to Home
// - Undriven selects read low, full step
// - Output disable kills transistors, translator runs
// - Sleep disables outputs; waking returns Home
// - Mixed: fast 31.25% of off-time
// - Comparator blanked 1us after switching
`include "mstp_defines.vh"
`timescale 1ns/100ps
`default_nettype none
module mstp_translator #(
	parameter TOFF_CYC = `MSTP_TOFF_CYC,
	parameter TBLANK_CYC = `MSTP_TBLANK_CYC,
	parameter FAST_CYC = `MSTP_FAST_CYC
)(
	input wire aclk,
	input wire aresetn,
	input wire clk_en,
	input wire advance_pin,
	input wire direction_pin,
	input wire resolution_select_a,
	input wire resolution_select_b,
	input wire reset_n_pin,
	input wire sleep_n_pin,
	input wire output_disable_pin,
	input wire offtime_setting_pin,
	input wire thermal_shutdown,
	input wire overcurrent,
	input wire [1:0] comparator_trip,
	input wire [3:0] s_axi_awaddr,
	input wire s_axi_awvalid,
	output wire s_axi_awready,
	input wire [31:0] s_axi_wdata,
	input wire [3:0] s_axi_wstrb,
	input wire s_axi_wvalid,
	output wire s_axi_wready,
	output reg [1:0] s_axi_bresp,
	output reg s_axi_bvalid,
	input wire s_axi_bready,
	input wire [3:0] s_axi_araddr,
	input wire s_axi_arvalid,
	output wire s_axi_arready,
	output reg [31:0] s_axi_rdata,
	output reg [1:0] s_axi_rresp,
	output reg s_axi_rvalid,
	input wire s_axi_rready,
	output reg [7:0] level_a,
	output reg [7:0] level_b,
	output reg polarity_a,
	output reg polarity_b,
	output reg [1:0] decay_mixed,
	output reg [3:0] source_on,
	output reg [3:0] sink_on
);

////////////////////////////////////////////////////////////////////////
// Input synchronisers
reg [11:0] sync1;
reg [11:0] sync2;
always @(posedge aclk)
begin
	if (clk_en)
	begin
		sync1 <= {resolution_select_b, resolution_select_a, output_disable_pin, comparator_trip, overcurrent,
			thermal_shutdown, offtime_setting_pin, sleep_n_pin, reset_n_pin, direction_pin, advance_pin};
		sync2 <= sync1;
	end
end
wire s_adv = sync2[0];
wire s_dir = sync2[1];
wire s_rst_n = sync2[2];
wire s_sleep_n = sync2[3];
wire s_offgnd = ~sync2[4];
wire s_fault = sync2[5] | sync2[6];
wire [1:0] s_trip = sync2[8:7];
wire s_outdis = sync2[9];
// Select pins: pull-downs make them low when open, full step default
wire [1:0] sel2 = sync2[11:10];

////////////////////////////////////////////////////////////////////////
// Software control: bit0 soft home, bit1 software output disable
reg [1:0] ctrl;
reg [15:0] step_count;
wire hold_home = ~aresetn | ~s_rst_n | ~s_sleep_n | s_fault | ctrl[0];

////////////////////////////////////////////////////////////////////////
// Translator: 16-entry quarter-cycle table at sixteenth resolution
reg adv_d;
reg [5:0] pos;
reg [5:0] incr;
always @*
begin
	case (sel2)
		2'b00: incr = 6'h10;
		2'b01: incr = 6'h08;
		2'b10: incr = 6'h04;
		default: incr = 6'h01;
	endcase
end
wire adv_edge = s_adv & ~adv_d;
wire [5:0] next_pos = s_dir ? pos + incr : pos - incr;
// Sine magnitude for 16 sub-steps of a quarter period
function [7:0] mstp_sine;
	input [3:0] idx;
	begin
		case (idx)
			4'h0: mstp_sine = 8'h00;
			4'h1: mstp_sine = 8'h19;
			4'h2: mstp_sine = 8'h31;
			4'h3: mstp_sine = 8'h4a;
			4'h4: mstp_sine = 8'h61;
			4'h5: mstp_sine = 8'h78;
			4'h6: mstp_sine = 8'h8e;
			4'h7: mstp_sine = 8'ha2;
			4'h8: mstp_sine = 8'hb5;
			4'h9: mstp_sine = 8'hc5;
			4'ha: mstp_sine = 8'hd4;
			4'hb: mstp_sine = 8'he1;
			4'hc: mstp_sine = 8'heb;
			4'hd: mstp_sine = 8'hf4;
			4'he: mstp_sine = 8'hfa;
			default: mstp_sine = 8'hfe;
		endcase
	end
endfunction
wire [3:0] qidx = next_pos[3:0];
wire [1:0] quad = next_pos[5:4];
wire [7:0] mag_lo = mstp_sine(qidx);
wire [7:0] mag_hi = (qidx == 4'h0) ? 8'hff : mstp_sine(4'h0 - qidx);
// Bridge A follows cosine, bridge B sine
wire [7:0] nlev_a = quad[0] ? mag_lo : mag_hi;
wire [7:0] nlev_b = quad[0] ? mag_hi : mag_lo;
wire npol_a = ~(quad == 2'b01 || quad == 2'b10);
wire npol_b = ~quad[1];

always @(posedge aclk)
begin
	if (clk_en)
	begin
		adv_d <= s_adv;
		if (hold_home)
		begin
			// Home state, advance edges dropped
			pos <= `MSTP_POS_HOME;
			level_a <= 8'hb5;
			level_b <= 8'hb5;
			polarity_a <= 1'b1;
			polarity_b <= 1'b1;
			decay_mixed <= {`MSTP_DEC_MIXED, `MSTP_DEC_MIXED};
			step_count <= 16'h0000;
		end
		else if (adv_edge)
		begin
			pos <= next_pos;
			level_a <= nlev_a;
			level_b <= nlev_b;
			polarity_a <= npol_a;
			polarity_b <= npol_b;
			// Falling level Mixed, else Slow; grounded pin forces Mixed
			decay_mixed[0] <= (nlev_a < level_a) | s_offgnd;
			decay_mixed[1] <= (nlev_b < level_b) | s_offgnd;
			step_count <= step_count + 16'h0001;
		end
		else if (s_offgnd)
			decay_mixed <= {`MSTP_DEC_MIXED, `MSTP_DEC_MIXED};
	end
end

////////////////////////////////////////////////////////////////////////
// Per-bridge chopper: on-phase, then fixed off-time
localparam ST_ON = 2'd0;
localparam ST_FAST = 2'd1;
localparam ST_SLOW = 2'd2;
wire outs_off = hold_home | s_outdis | ctrl[1];
wire [1:0] pol = {polarity_b, polarity_a};
wire step_sw = adv_edge & ~hold_home;
genvar g;
generate
	for (g = 0; g < 2; g = g + 1)
	begin : gen_bridge
		reg [1:0] state;
		reg [15:0] cnt;
		reg [15:0] blank;
		always @(posedge aclk)
		begin
			if (clk_en)
			begin
				if (outs_off)
				begin
					state <= ST_ON;
					cnt <= 16'h0000;
					blank <= TBLANK_CYC[15:0];
				end
				else
				begin
					cnt <= cnt + 16'h0001;
					case (state)
						ST_ON:
						begin
							if (blank != 16'h0000)
								blank <= blank - 16'h0001;
							else if (s_trip[g])
							begin
								// Trip resets the chopping latch
								state <= decay_mixed[g] ? ST_FAST : ST_SLOW;
								cnt <= 16'h0001;
								blank <= TBLANK_CYC[15:0];
							end
							if (step_sw)
								blank <= TBLANK_CYC[15:0];
						end
						ST_FAST:
						begin
							if (cnt >= FAST_CYC[15:0])
								state <= ST_SLOW;
						end
						default:
						begin
							if (cnt >= TOFF_CYC[15:0])
							begin
								state <= ST_ON;
								cnt <= 16'h0000;
								blank <= TBLANK_CYC[15:0];
							end
						end
					endcase
				end
			end
		end
		// Transistors: [1]=leg1 [0]=leg2; diagonal pair per polarity
		always @(posedge aclk)
		begin
			if (clk_en)
			begin
				if (outs_off)
				begin
					source_on[2*g+1:2*g] <= 2'b00;
					sink_on[2*g+1:2*g] <= 2'b00;
				end
				else if (state == ST_ON)
				begin
					source_on[2*g+1:2*g] <= pol[g] ? 2'b10 : 2'b01;
					sink_on[2*g+1:2*g] <= pol[g] ? 2'b01 : 2'b10;
				end
				else if (state == ST_FAST)
				begin
					// Reverse diagonal: source and sink of on-pair off
					source_on[2*g+1:2*g] <= pol[g] ? 2'b01 : 2'b10;
					sink_on[2*g+1:2*g] <= pol[g] ? 2'b10 : 2'b01;
				end
				else
				begin
					// Slow: source off, both sinks recirculate
					source_on[2*g+1:2*g] <= 2'b00;
					sink_on[2*g+1:2*g] <= 2'b11;
				end
			end
		end
	end
endgenerate

////////////////////////////////////////////////////////////////////////
// AXI4-Lite slave
reg aw_held;
reg w_held;
reg [3:0] aw_addr;
reg [31:0] w_data;
reg [3:0] w_strb;
assign s_axi_awready = ~aw_held & ~s_axi_bvalid;
assign s_axi_wready = ~w_held & ~s_axi_bvalid;
assign s_axi_arready = ~s_axi_rvalid;
wire aw_go = aw_held | s_axi_awvalid;
wire w_go = w_held | s_axi_wvalid;
wire [3:0] wr_addr = aw_held ? aw_addr : s_axi_awaddr;
wire [31:0] wr_data = w_held ? w_data : s_axi_wdata;
wire [3:0] wr_strb = w_held ? w_strb : s_axi_wstrb;
wire wr_do = aw_go & w_go & ~s_axi_bvalid;
always @(posedge aclk)
begin
	if (!aresetn)
	begin
		aw_held <= 1'b0;
		w_held <= 1'b0;
		s_axi_bvalid <= 1'b0;
		s_axi_bresp <= 2'b00;
		s_axi_rvalid <= 1'b0;
		s_axi_rresp <= 2'b00;
		s_axi_rdata <= 32'h00000000;
		ctrl <= `MSTP_CTRL_RST;
	end
	else if (clk_en)
	begin
		if (s_axi_bvalid && s_axi_bready)
			s_axi_bvalid <= 1'b0;
		if (wr_do)
		begin
			aw_held <= 1'b0;
			w_held <= 1'b0;
			s_axi_bvalid <= 1'b1;
			if (wr_addr == `MSTP_ADDR_CTRL)
			begin
				s_axi_bresp <= 2'b00;
				if (wr_strb[0])
					ctrl <= wr_data[1:0];
			end
			else if (wr_addr == `MSTP_ADDR_STAT || wr_addr == `MSTP_ADDR_LEVEL)
				s_axi_bresp <= 2'b00;
			else
				s_axi_bresp <= 2'b10;
		end
		else
		begin
			if (s_axi_awvalid && s_axi_awready)
			begin
				aw_held <= 1'b1;
				aw_addr <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready)
			begin
				w_held <= 1'b1;
				w_data <= s_axi_wdata;
				w_strb <= s_axi_wstrb;
			end
		end
		if (s_axi_rvalid && s_axi_rready)
			s_axi_rvalid <= 1'b0;
		else if (s_axi_arvalid && s_axi_arready)
		begin
			s_axi_rvalid <= 1'b1;
			s_axi_rresp <= 2'b00;
			if (s_axi_araddr == `MSTP_ADDR_CTRL)
				s_axi_rdata <= {30'h0, ctrl};
			else if (s_axi_araddr == `MSTP_ADDR_STAT)
				s_axi_rdata <= {step_count, 2'b00, pos, 2'b00, sel2, decay_mixed, outs_off, hold_home};
			else if (s_axi_araddr == `MSTP_ADDR_LEVEL)
				s_axi_rdata <= {6'h0, polarity_b, polarity_a, level_b, 8'h0, level_a};
			else
			begin
				s_axi_rdata <= 32'h00000000;
				s_axi_rresp <= 2'b10;
			end
		end
	end
end

endmodule
`default_nettype wire

// ===== sim/mstp_step_ctl.sv
// Purpose: Controller model giving advance pulses
// Assumes: 50 MHz aclk
// Notes: High and low phases each HOLD_CYC cycles
`timescale 1ns/100ps
`default_nettype none
module mstp_step_ctl #(
	parameter int HOLD_CYC = 50
)(
	input wire logic aclk,
	input wire logic go,
	output logic advance_pin,
	output logic busy
);
	int cnt = 0;
	assign busy = cnt != 0;
	assign advance_pin = cnt > HOLD_CYC;
	always @(posedge aclk)
	begin
		cnt <= go && !busy ? 2 * HOLD_CYC : cnt - busy;
	end
endmodule
`default_nettype wire

// ===== sim/mstp_translator_checker.sv
// Purpose: Assertions on the translator ports
// Assumes: One aclk domain, sync low aresetn
// Notes: Pin effects get a few cycles of sync delay
`timescale 1ns/100ps
`default_nettype none
module mstp_chk (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic reset_n_pin,
	input wire logic sleep_n_pin,
	input wire logic output_disable_pin,
	input wire logic offtime_setting_pin,
	input wire logic thermal_shutdown,
	input wire logic overcurrent,
	input wire logic [7:0] level_a,
	input wire logic [7:0] level_b,
	input wire logic polarity_a,
	input wire logic polarity_b,
	input wire logic [1:0] decay_mixed,
	input wire logic [3:0] source_on,
	input wire logic [3:0] sink_on
);
	wire run = reset_n_pin & sleep_n_pin & ~thermal_shutdown & ~overcurrent & offtime_setting_pin;
	wire off = source_on == 4'h0 && sink_on == 4'h0;
	wire home = {polarity_b, polarity_a, level_b, level_a} == 18'h3b5b5;
	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);
	sequence settled;
		run [*8];
	endsequence
	reset_home_a: assert property ($rose(aresetn) |-> home && off && decay_mixed == 2'h3)
		else $error("Bad reset state");
	pin_home_a: assert property (!reset_n_pin [*6] |-> home && off)
		else $error("Reset pin not home");
	pin_ignore_a: assert property (!reset_n_pin [*6] |=> $stable(level_a))
		else $error("Step during reset");
	disable_off_a: assert property (output_disable_pin [*4] |-> off)
		else $error("Outputs on while disabled");
	sleep_off_a: assert property (!sleep_n_pin [*6] |-> off)
		else $error("Outputs on in sleep");
	fault_home_a: assert property ((thermal_shutdown | overcurrent) [*6] |-> home && off)
		else $error("Fault not home");
	forced_mixed_a: assert property (!offtime_setting_pin [*4] |-> decay_mixed == 2'h3)
		else $error("Decay not forced");
	auto_decay_a: assert property (settled ##0 $changed(level_a) |->
		decay_mixed[0] == (level_a < $past(level_a))) else $error("Wrong decay");
endmodule
bind mstp_translator mstp_chk u_mstp_chk (.*);
`default_nettype wire

// ===== sim/tb.sv
// Purpose: Self-checking bench for the step translator
// Assumes: 50 MHz aclk, short chopper counts
// Notes: Selects and direction come from an LFSR after four fixed pulses
`timescale 1ns/100ps
`default_nettype none
module tb;
	logic aclk = 0, aresetn = 0, clk_en = 1, go = 0, direction_pin = 1, resolution_select_a = 0;
	logic resolution_select_b = 0, reset_n_pin = 1, sleep_n_pin = 1, output_disable_pin = 0;
	logic offtime_setting_pin = 1, thermal_shutdown = 0, overcurrent = 0, s_axi_awvalid = 0, s_axi_wvalid = 0;
	logic s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0, s_axi_awready, s_axi_wready, s_axi_bvalid;
	logic s_axi_arready, s_axi_rvalid, polarity_a, polarity_b, advance_pin, busy;
	logic [1:0] comparator_trip = 0, rr, s_axi_bresp, s_axi_rresp, decay_mixed;
	logic [3:0] s_axi_awaddr = 0, s_axi_araddr = 0, s_axi_wstrb = 4'hf, source_on, sink_on;
	logic [31:0] s_axi_wdata = 0, s_axi_rdata, rd, seed = 32'hd00e;
	logic [7:0] level_a, level_b;
	logic [5:0] pos = 6'h08;
	int err_total = 0, comparisons = 0, cyc = 0, i;
	mstp_translator #(.TOFF_CYC(40), .TBLANK_CYC(5), .FAST_CYC(12)) u_mstp_translator (.*);
	mstp_step_ctl u_mstp_step_ctl (.*);
	function logic [31:0] lfsr(input logic [31:0] s);
		lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	function logic [5:0] nxt(input logic [5:0] p, input logic d, a, b);
		nxt = b ? (a ? 6'h01 : 6'h04) : (a ? 6'h08 : 6'h10);
		nxt = d ? p + nxt : p - nxt;
	endfunction
	task chk(input logic [35:0] got, input logic [35:0] exp);
		comparisons++;
		if (got !== exp)
		begin
			err_total++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task complete_run;
		$display("Comparisons %0d, mismatches %0d", comparisons, err_total);
		if (err_total == 0 && comparisons > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	task axw(input logic [3:0] a, input logic [31:0] d);
		@(posedge aclk);
		{s_axi_awaddr, s_axi_wdata, s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= {a, d, 3'h7};
		do
		begin
			@(posedge aclk);
			if (s_axi_awready)
				s_axi_awvalid <= 0;
			if (s_axi_wready)
				s_axi_wvalid <= 0;
		end while (!s_axi_bvalid);
		s_axi_bready <= 0;
		rr = s_axi_bresp;
	endtask
	task axr(input logic [3:0] a);
		@(posedge aclk);
		{s_axi_araddr, s_axi_arvalid, s_axi_rready} <= {a, 2'h3};
		do
		begin
			@(posedge aclk);
			if (s_axi_arready)
				s_axi_arvalid <= 0;
		end while (!s_axi_rvalid);
		s_axi_rready <= 0;
		{rr, rd} = {s_axi_rresp, s_axi_rdata};
	endtask
	// Selects change mid-pulse and must wait for the next edge
	task pulse(input logic upd, input logic [2:0] nv);
		go <= 1;
		@(posedge aclk);
		go <= 0;
		repeat (20) @(posedge aclk);
		if (upd)
			pos = nxt(pos, direction_pin, resolution_select_a, resolution_select_b);
		{resolution_select_b, resolution_select_a, direction_pin} <= nv;
		while (busy)
			@(posedge aclk);
		axr(4'h4);
		chk(rd[13:8], pos);
	endtask
	initial
	begin
		forever
			#10 aclk = ~aclk;
	end
	always @(posedge aclk)
	begin
		seed <= lfsr(seed);
		comparator_trip <= seed[9:8];
		cyc <= cyc + 1;
		if (cyc == 70000)
		begin
			err_total++;
			complete_run;
		end
	end
	initial
	begin
		repeat (5) @(posedge aclk);
		aresetn <= 1;
		axr(4'h8);
		chk({rr, rd}, 36'h003b500b5);
		axw(4'hc, seed);
		chk(rr, 2'h2);
		axr(4'hc);
		chk({rr, rd}, 36'h200000000);
		axw(4'h0, 32'h2);
		axr(4'h0);
		chk({rr, rd[1:0], source_on, sink_on}, 12'h200);
		axw(4'h0, 32'h0);
		for (i = 0; i < 40; i++)
		begin
			offtime_setting_pin <= i < 30;
			output_disable_pin <= seed[7];
			pulse(1, i < 4 ? {i[1:0], 1'b1} : seed[2:0]); // model tracks absolute position
		end
		offtime_setting_pin <= 1;
		output_disable_pin <= 0;
		for (i = 0; i < 4; i++)
		begin
			pulse(1, seed[2:0]);
			{sleep_n_pin, overcurrent, thermal_shutdown, reset_n_pin} <= 4'h9 ^ (4'h1 << i);
			pos = 6'h08;
			pulse(0, seed[2:0]);
			chk({polarity_b, polarity_a, level_b, level_a, source_on, sink_on}, 26'h3b5b500);
			{sleep_n_pin, overcurrent, thermal_shutdown, reset_n_pin} <= 4'h9;
			repeat (i == 3 ? 50000 : 8) @(posedge aclk);
		end
		complete_run;
	end
endmodule
`default_nettype wire
